//--- hw/irq_pm.sv
// interrupt dispatch and power mode control
`timescale 1ns/1ps
module irq_pm #(
    parameter int N = irq_pm_pkg::N_SRC
) (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 resetn,
    // register port
    input  wire logic [7:0]           addr,
    input  wire logic [15:0]          wdata,
    input  wire logic                 wr,
    input  wire logic                 rd,
    output logic      [15:0]          rdata,
    // core sequencer and sources
    input  wire irq_pm_pkg::core_seq_t seq,
    input  wire logic [N-1:0]         irq_flags,
    // outputs to core and peripherals
    output irq_pm_pkg::call_t         call,
    output logic                      core_halt,
    output logic                      osc_stop,
    output logic                      periph_off,
    output logic                      low_voltage_reset_disable,
    output logic                      core_restart,
    output logic [7:0]                power_control
);

    irq_pm_pkg::state_t s, n;

    // vector lookup
    function automatic logic [irq_pm_pkg::VEC_W-1:0] vec_of(input int i);
        case (i)
            irq_pm_pkg::SRC_EXT0: vec_of = irq_pm_pkg::VEC_EXT0;
            irq_pm_pkg::SRC_SER1: vec_of = irq_pm_pkg::VEC_SER1;
            irq_pm_pkg::SRC_TMR0: vec_of = irq_pm_pkg::VEC_TMR0;
            irq_pm_pkg::SRC_I2C:  vec_of = irq_pm_pkg::VEC_I2C;
            irq_pm_pkg::SRC_EXT1: vec_of = irq_pm_pkg::VEC_EXT1;
            irq_pm_pkg::SRC_TMR1: vec_of = irq_pm_pkg::VEC_TMR1;
            irq_pm_pkg::SRC_USB:  vec_of = irq_pm_pkg::VEC_USB;
            irq_pm_pkg::SRC_SER0: vec_of = irq_pm_pkg::VEC_SER0;
            default:              vec_of = irq_pm_pkg::VEC_TMR2;
        endcase
    endfunction : vec_of

    logic [N-1:0] pend;
    logic         found;
    logic         found_hi;
    int           sel;
    logic         blocked;

    // next-state logic
    always_comb begin
        n = s;
        pend = '0;
        found = 1'b0;
        found_hi = 1'b0;
        sel = 0;
        blocked = 1'b0;
        n.call_r.hw_long_call = 1'b0;
        n.call_r.push_pc = 1'b0;
        n.call_r.pop_pc = 1'b0;
        n.core_restart_r = 1'b0;
        n.rdata_r = '0;

        // capture flags at the sample phase, held for the next machine cycle
        if (seq.flag_sample_phase) begin
            n.sampled_r = irq_flags;
        end

        // enabled requests; global enable gates all
        pend = s.sampled_r & s.enable_r[N-1:0] & {N{s.enable_r[irq_pm_pkg::EN_GLOBAL]}};

        // high level first, then polling order
        for (int i = N - 1; i >= 0; i--) begin
            if (pend[i] && s.priority_r[i]) begin
                found_hi = 1'b1;
                sel = i;
            end
        end
        if (!found_hi) begin
            for (int i = N - 1; i >= 0; i--) begin
                if (pend[i]) begin
                    found = 1'b1;
                    sel = i;
                end
            end
        end else begin
            found = 1'b1;
        end

        // blocking conditions
        blocked = s.in_prog_r[1] || (s.in_prog_r[0] && !found_hi)
                  || (!seq.last_cycle && s.pm_r == irq_pm_pkg::PM_RUN)
                  || seq.is_return_from_interrupt || seq.is_irq_reg_access
                  || s.pm_r == irq_pm_pkg::PM_PD || s.pm_r == irq_pm_pkg::PM_WAKE;

        // polling cycle: issue call and mark level busy
        if (seq.flag_sample_phase && found && !blocked) begin
            n.call_r.hw_long_call = 1'b1;
            n.call_r.push_pc = 1'b1;
            n.call_r.vector = vec_of(sel);
            n.in_prog_r[found_hi] = 1'b1;
            if (s.pm_r == irq_pm_pkg::PM_IDLE) begin
                n.power_control_r[irq_pm_pkg::PC_IDLE] = 1'b0;
                n.pm_r = irq_pm_pkg::PM_RUN;
                n.core_halt_r = 1'b0;
            end
        end else if (seq.is_return_from_interrupt && seq.last_cycle) begin
            // highest active level ends, pc popped
            if (s.in_prog_r[1]) begin
                n.in_prog_r[1] = 1'b0;
            end else begin
                n.in_prog_r[0] = 1'b0;
            end
            n.call_r.pop_pc = 1'b1;
        end
        // plain return: pc popped, in-progress left untouched
        if (seq.is_plain_return && seq.last_cycle) begin
            n.call_r.pop_pc = 1'b1;
        end

        // register writes; power-down blocks the core so none arrive then
        if (wr) begin
            unique case (addr)
                irq_pm_pkg::ADDR_POWER_CONTROL: begin
                    n.power_control_r = wdata[7:0];
                    if (wdata[irq_pm_pkg::PC_PD]) begin
                        n.pm_r = irq_pm_pkg::PM_PD;
                        n.osc_stop_r = 1'b1;
                        n.periph_off_r = 1'b1;
                        n.core_halt_r = 1'b1;
                    end else if (wdata[irq_pm_pkg::PC_IDLE]) begin
                        n.pm_r = irq_pm_pkg::PM_IDLE;
                        n.core_halt_r = 1'b1;
                    end
                end
                irq_pm_pkg::ADDR_IRQ_ENABLE:   n.enable_r = wdata;
                irq_pm_pkg::ADDR_IRQ_PRIORITY: n.priority_r = wdata[N-1:0];
                default: ;
            endcase
        end

        // register reads, data valid next cycle
        if (rd) begin
            unique case (addr)
                irq_pm_pkg::ADDR_POWER_CONTROL: n.rdata_r = {8'h00, s.power_control_r};
                irq_pm_pkg::ADDR_IRQ_ENABLE:    n.rdata_r = s.enable_r;
                irq_pm_pkg::ADDR_IRQ_PRIORITY:  n.rdata_r = 16'(s.priority_r);
                irq_pm_pkg::ADDR_IRQ_STATUS:    n.rdata_r = {10'h000, s.pm_r, s.in_prog_r, s.core_halt_r, s.osc_stop_r};
                default:                        n.rdata_r = 16'h0000;
            endcase
        end

        // internal reset ending idle: restart after fixed machine cycles
        if (seq.internal_reset && s.pm_r == irq_pm_pkg::PM_IDLE) begin
            n.pm_r = irq_pm_pkg::PM_WAKE;
            n.wake_cnt_r = '0;
            n.in_prog_r = '0;
            n.power_control_r = irq_pm_pkg::RST_POWER_CONTROL;
        end else if (s.pm_r == irq_pm_pkg::PM_WAKE && seq.flag_sample_phase) begin
            if (s.wake_cnt_r == 2'(irq_pm_pkg::RESTART_MC - 1)) begin
                n.pm_r = irq_pm_pkg::PM_RUN;
                n.core_halt_r = 1'b0;
                n.core_restart_r = 1'b1;
            end else begin
                n.wake_cnt_r = s.wake_cnt_r + irq_pm_pkg::MC_CNT_W_ONE;
            end
        end
    end

    // state register; power-down ends only via resetn (external reset held two cycles by the board)
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s <= '0;
            s.power_control_r <= irq_pm_pkg::RST_POWER_CONTROL;
            s.pm_r <= irq_pm_pkg::PM_RUN;
        end else begin
            s <= n;
        end
    end

    // outputs straight from state flops
    assign rdata = s.rdata_r;
    assign call = s.call_r;
    assign core_halt = s.core_halt_r;
    assign osc_stop = s.osc_stop_r;
    assign periph_off = s.periph_off_r;
    assign core_restart = s.core_restart_r;
    assign power_control = s.power_control_r;
    assign low_voltage_reset_disable = s.power_control_r[irq_pm_pkg::PC_LVR_DIS];

    // call only when enabled, and in the last cycle unless idle
    a_call_gated: assert property (@(posedge clk) disable iff (!resetn)
        n.call_r.hw_long_call |-> (seq.last_cycle || s.pm_r == irq_pm_pkg::PM_IDLE))
        else $error("call outside last cycle");
    a_no_call_return_from_interrupt: assert property (@(posedge clk) disable iff (!resetn)
        seq.is_return_from_interrupt |=> !call.hw_long_call)
        else $error("call during interrupt return");
    a_global_block: assert property (@(posedge clk) disable iff (!resetn)
        !s.enable_r[irq_pm_pkg::EN_GLOBAL] |=> !call.hw_long_call)
        else $error("call with global enable clear");
    a_high_blocks: assert property (@(posedge clk) disable iff (!resetn)
        s.in_prog_r[1] |=> !call.hw_long_call)
        else $error("call while high level active");
    a_call_marks: assert property (@(posedge clk) disable iff (!resetn)
        call.hw_long_call |-> s.in_prog_r != 2'b00)
        else $error("call without in-progress");
    a_pd_sticky: assert property (@(posedge clk) disable iff (!resetn)
        s.pm_r == irq_pm_pkg::PM_PD |=> s.pm_r == irq_pm_pkg::PM_PD && osc_stop)
        else $error("power-down left without reset");
    a_pd_wins: assert property (@(posedge clk) disable iff (!resetn)
        wr && addr == irq_pm_pkg::ADDR_POWER_CONTROL && wdata[irq_pm_pkg::PC_PD]
        |=> s.pm_r == irq_pm_pkg::PM_PD)
        else $error("power-down not entered");
    a_plain_ret: assert property (@(posedge clk) disable iff (!resetn)
        seq.is_plain_return && !seq.is_return_from_interrupt && !seq.internal_reset
        |=> s.in_prog_r[1] == $past(s.in_prog_r[1]) || call.hw_long_call)
        else $error("plain return cleared level");

endmodule : irq_pm

//--- common/irq_pm_pkg.sv
// package: constants and carriers for the interrupt dispatch and power mode block
package irq_pm_pkg;

    localparam int N_SRC = 9;
    localparam int VEC_W = 16;

    // source indices in fixed polling order, ext_irq_0 first
    localparam int SRC_EXT0   = 0;
    localparam int SRC_SER1   = 1;
    localparam int SRC_TMR0   = 2;
    localparam int SRC_I2C    = 3;
    localparam int SRC_EXT1   = 4;
    localparam int SRC_TMR1   = 5;
    localparam int SRC_USB    = 6;
    localparam int SRC_SER0   = 7;
    localparam int SRC_TMR2   = 8;

    // vector addresses per source
    localparam logic [VEC_W-1:0] VEC_EXT0 = 16'h0003;
    localparam logic [VEC_W-1:0] VEC_TMR0 = 16'h000B;
    localparam logic [VEC_W-1:0] VEC_EXT1 = 16'h0013;
    localparam logic [VEC_W-1:0] VEC_TMR1 = 16'h001B;
    localparam logic [VEC_W-1:0] VEC_SER0 = 16'h0023;
    localparam logic [VEC_W-1:0] VEC_TMR2 = 16'h002B;
    localparam logic [VEC_W-1:0] VEC_USB  = 16'h0033;
    localparam logic [VEC_W-1:0] VEC_I2C  = 16'h0043;
    localparam logic [VEC_W-1:0] VEC_SER1 = 16'h004B;

    // register map
    localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
    localparam logic [7:0] ADDR_IRQ_ENABLE    = 8'hA8;
    localparam logic [7:0] ADDR_IRQ_PRIORITY  = 8'hB8;
    localparam logic [7:0] ADDR_IRQ_STATUS    = 8'hC0;
    localparam logic [7:0] RST_POWER_CONTROL  = 8'h00;

    // power_control fields
    localparam int PC_IDLE = 0;
    localparam int PC_PD   = 1;
    localparam int PC_LVR_DIS = 5;  // low voltage reset disable, active high

    // enable register: bit 15 global, low bits per source
    localparam int EN_GLOBAL = 15;

    // restart delay after internal reset that ends idle, in machine cycles
    localparam int RESTART_MC = 3;
    localparam logic [1:0] MC_CNT_W_ONE = 2'h1;

    typedef enum logic [1:0] {
        PM_RUN  = 2'b00,
        PM_IDLE = 2'b01,
        PM_PD   = 2'b10,
        PM_WAKE = 2'b11
    } pm_state_t;

    // core sequencer handshake toward this block
    typedef struct packed {
        logic flag_sample_phase;  // one pulse per machine cycle
        logic last_cycle;         // final cycle of current instruction
        logic is_return_from_interrupt;
        logic is_irq_reg_access;
        logic is_plain_return;
        logic internal_reset;     // pulse: internal reset source
    } core_seq_t;

    // hardware call toward core
    typedef struct packed {
        logic             hw_long_call;
        logic [VEC_W-1:0] vector;
        logic             push_pc;     // push pc, program_status_word not saved
        logic             pop_pc;      // pop two bytes into pc
    } call_t;

    typedef struct packed {
        logic [N_SRC-1:0] sampled_r;
        logic [1:0]       in_prog_r;     // [1] high level, [0] low level
        logic [15:0]      enable_r;
        logic [N_SRC-1:0] priority_r;
        logic [7:0]       power_control_r;
        pm_state_t        pm_r;
        logic [1:0]       wake_cnt_r;
        call_t            call_r;
        logic [15:0]      rdata_r;
        logic             core_halt_r;
        logic             osc_stop_r;
        logic             periph_off_r;
        logic             core_restart_r;
    } state_t;

endpackage : irq_pm_pkg

//--- testbench/core_model.sv
// core sequencer stand-in: machine cycle phase and instruction status toward the block
`timescale 1ns/1ps
module core_model #(
    parameter int MC = 4
) (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  resetn,
    // status asked for by the bench: last, return_from_interrupt, reg access, plain_return, internal reset
    input  wire logic [4:0]            status,
    // toward the block
    output irq_pm_pkg::core_seq_t      seq
);
    logic [3:0] phase_r;
    // free running machine cycle phase counter
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            phase_r <= 4'h0;
        end else begin
            phase_r <= (phase_r == 4'(MC - 1)) ? 4'h0 : phase_r + 4'h1;
        end
    end
    // one flag_sample_phase pulse per machine cycle, status passed through as levels
    assign seq = {resetn && (phase_r == 4'(MC - 1)), status};
endmodule : core_model

//--- testbench/tb_top.sv
// self-checking bench for the interrupt dispatch and power mode block
`timescale 1ns/1ps
module tb_top;
    localparam int MC = 4;
    localparam logic [15:0] VEC_EXP [9] = '{16'h0003, 16'h004B, 16'h000B, 16'h0043, 16'h0013,
                                            16'h001B, 16'h0033, 16'h0023, 16'h002B};
    localparam logic [4:0]  BLK [4]     = '{5'h00, 5'h18, 5'h14, 5'h10};
    logic                  clk         = 1'b0;
    logic                  resetn      = 1'b0;
    logic [7:0]            addr        = 8'h00;
    logic [15:0]           wdata       = 16'h0000;
    logic                  wr          = 1'b0;
    logic                  rd          = 1'b0;
    logic [4:0]            status      = 5'h10;
    logic [8:0]            irq_flags   = 9'h000;
    logic [31:0]           seed        = 32'h3019;
    logic [15:0]           rdata, rv;
    logic                  core_halt, osc_stop, periph_off, lvr_dis, core_restart, got;
    logic [7:0]            power_control;
    irq_pm_pkg::core_seq_t seq;
    irq_pm_pkg::call_t     call;
    int                    err_total   = 0;
    int                    comparisons = 0;
    int                    cnt;
    // 100 ns clock
    always #50 clk = ~clk;
    core_model #(.MC(MC)) u_core (.clk(clk), .resetn(resetn), .status(status), .seq(seq));
    irq_pm u_dut (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .seq(seq), .irq_flags(irq_flags), .call(call), .core_halt(core_halt), .osc_stop(osc_stop),
        .periph_off(periph_off), .low_voltage_reset_disable(lvr_dis), .core_restart(core_restart),
        .power_control(power_control));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask : rd_reg
    task automatic mcs(input int n);
        repeat (n * MC) @(posedge clk);
    endtask : mcs
    // watch up to n cycles for a call (0), pop (1) or restart (2) pulse
    task automatic scan(input int n, input int which, output logic hit);
        hit = 1'b0;
        for (int i = 0; i < n && hit !== 1'b1; i++) begin
            @(negedge clk);
            hit = (which == 0) ? call.hw_long_call : (which == 1) ? call.pop_pc : core_restart;
            rv = call.vector;
        end
    endtask : scan
    task automatic serve(input int s);
        @(posedge clk);
        irq_flags[s] <= 1'b1;
        scan(4 * MC, 0, got);
        check("call", got, 1'b1);
        check("vector", rv, VEC_EXP[s]);
        check("push", call.push_pc, 1'b1);
        @(posedge clk);
        irq_flags[s] <= 1'b0;
    endtask : serve
    // let one sample phase pass so cleared flags are captured, then one-edge interrupt return
    task automatic return_from_interrupt();
        mcs(1);
        @(posedge clk);
        status <= 5'h18;
        @(posedge clk);
        status <= 5'h10;
        scan(2 * MC, 1, got);
        check("pop", got, 1'b1);
    endtask : return_from_interrupt
    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        wr_reg(8'h5A, 16'hFFFF);
        rd_reg(8'h5A, rv);
        check("unmapped", rv, 16'h0000);
        rd_reg(8'h87, rv);
        check("power_control reset", rv, 16'h0000);
        $display("test reset done");
        wr_reg(8'hA8, 16'h81FF);
        for (int s = 0; s < 9; s++) begin
            serve(s);
            return_from_interrupt();
        end
        $display("test vectors done");
        // all flags at once, then raise one source to high level
        @(posedge clk);
        irq_flags <= 9'h1FF;
        scan(4 * MC, 0, got);
        check("tie order", rv, VEC_EXP[0]);
        wr_reg(8'hB8, 16'h0100);
        scan(4 * MC, 0, got);
        check("preempt", rv, VEC_EXP[8]);
        scan(4 * MC, 0, got);
        check("high blocks", got, 1'b0);
        @(posedge clk);
        irq_flags <= 9'h000;
        return_from_interrupt();
        return_from_interrupt();
        wr_reg(8'hB8, 16'h0000);
        $display("test priority done");
        // plain return keeps the level busy
        serve(1);
        @(posedge clk);
        status <= 5'h12;
        mcs(1);
        status <= 5'h10;
        irq_flags[2] <= 1'b1;
        scan(4 * MC, 0, got);
        check("after plain", got, 1'b0);
        return_from_interrupt();
        scan(4 * MC, 0, got);
        check("served late", rv, VEC_EXP[2]);
        @(posedge clk);
        irq_flags[2] <= 1'b0;
        return_from_interrupt();
        $display("test plain return done");
        // not last cycle, return_from_interrupt, reg access, global enable off
        for (int k = 0; k < 4; k++) begin
            if (k == 3) wr_reg(8'hA8, 16'h01FF);
            @(posedge clk);
            status <= BLK[k];
            irq_flags[4] <= 1'b1;
            scan(3 * MC, 0, got);
            check("blocked", got, 1'b0);
            @(posedge clk);
            irq_flags[4] <= 1'b0;
            mcs(2);
            status <= 5'h10;
            if (k == 3) wr_reg(8'hA8, 16'h81FF);
            scan(3 * MC, 0, got);
            check("forgotten", got, 1'b0);
        end
        $display("test blocking done");
        repeat (4) begin
            seed = lfsr(seed);
            wr_reg(8'h87, {8'h00, seed[7:2], 2'b00});
            rd_reg(8'h87, rv);
            check("power_control rw", rv, {8'h00, seed[7:2], 2'b00});
            check("lvr disable", lvr_dis, seed[5]);
        end
        $display("test power control done");
        wr_reg(8'h87, 16'h0001);
        rd_reg(8'h87, rv);
        check("idle halt", core_halt, 1'b1);
        check("idle osc", osc_stop, 1'b0);
        check("idle periph", periph_off, 1'b0);
        serve(0);
        rd_reg(8'h87, rv);
        check("idle cleared", rv, 16'h0000);
        check("idle exit", core_halt, 1'b0);
        return_from_interrupt();
        // internal reset during idle, launched just after a sample edge
        wr_reg(8'h87, 16'h0001);
        mcs(2);
        for (int i = 0; i < MC && seq.flag_sample_phase !== 1'b1; i++) @(negedge clk);
        @(posedge clk);
        status <= 5'h11;
        @(posedge clk);
        status <= 5'h10;
        cnt = 0;
        got = 1'b0;
        for (int i = 0; i < 8 * MC && got !== 1'b1; i++) begin
            @(negedge clk);
            got = core_restart;
            if (seq.flag_sample_phase === 1'b1) cnt++;
        end
        check("restart", got, 1'b1);
        check("restart mc", cnt[15:0], 16'h0003);
        $display("test idle done");
        // both bits at once: power-down wins, interrupts do not wake
        wr_reg(8'h87, 16'h0003);
        mcs(2);
        irq_flags[0] <= 1'b1;
        scan(4 * MC, 0, got);
        check("pd no call", got, 1'b0);
        check("pd osc", osc_stop, 1'b1);
        check("pd periph", periph_off, 1'b1);
        @(posedge clk);
        irq_flags[0] <= 1'b0;
        resetn <= 1'b0;
        mcs(2);
        resetn <= 1'b1;
        rd_reg(8'h87, rv);
        check("pd reset", rv, 16'h0000);
        check("pd osc off", osc_stop, 1'b0);
        $display("test power-down done");
        close_out();
    end
endmodule : tb_top
